// >>> dcp_div_if.sv
`timescale 1ns/100ps
interface dcp_div_if;
  import dcp_pkg::*;
  logic [OUT_DIV_N-1:0] power_on;
  logic [OUT_DIV_N-1:0] clk_off;
  logic [OUT_DIV_N-1:0] integer_sel;
  logic [ROUTE_W-1:0] route;
  logic [OUT_DIV_N-1:0] run;
  logic [OUT_DIV_N-1:0] clk_gate_en;
  logic [OUT_DIV_N-1:0] mode;
  logic [ROUTE_W-1:0] route_out;

  modport regs (
    output power_on, clk_off, integer_sel, route,
    input run, clk_gate_en, mode, route_out
  );

  modport ctrl (
    input power_on, clk_off, integer_sel, route,
    output run, clk_gate_en, mode, route_out
  );
endinterface

// >>> dcp_divider_cfg.sv
`timescale 1ns/100ps
// Contract
// - Per output divider, 1 integer, 0 fractional
// - Power bit 0 powers divider down
// - Bits 3:0 stop input divider clocks
// - Bit 5 stops feedback divider clock
// - Clock-disable bit gates output divider clock
// - Two-bit field routes dividers to drivers
module dcp_divider_cfg (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic [dcp_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [dcp_pkg::DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [dcp_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [dcp_pkg::DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [dcp_pkg::OUT_DIV_N-1:0] out_div_integer_sel,
  output logic [dcp_pkg::OUT_DIV_N-1:0] out_div_power_on,
  output logic [dcp_pkg::OUT_DIV_N-1:0] out_div_clk_en,
  output logic [dcp_pkg::OUT_DIV_N-1:0] out_div_run,
  output logic [dcp_pkg::IN_DIV_N-1:0] input_frac_div_clk_off,
  output logic feedback_frac_div_clk_off,
  output logic [dcp_pkg::ROUTE_W-1:0] out_drv_route
);
  import dcp_pkg::*;

  function automatic logic [SEL_N-1:0] dec_idx(input logic [ADDR_W-1:0] a);
    logic [IDX_W-1:0] idx;
    idx = a[ADDR_W-1:2];
    dec_idx = '0;
    dec_idx[SEL_ROUTE] = (idx == IDX_ROUTE);
    dec_idx[SEL_INT_MODE] = (idx == IDX_INT_MODE);
    dec_idx[SEL_PWR] = (idx == IDX_PWR);
    dec_idx[SEL_FRAC_GATE] = (idx == IDX_FRAC_GATE);
    dec_idx[SEL_OUT_GATE] = (idx == IDX_OUT_GATE);
    dec_idx[SEL_STATUS] = (idx == IDX_STATUS);
  endfunction

  // Configuration registers
  logic [ROUTE_W-1:0] route_q;
  logic [OUT_DIV_N-1:0] int_mode_q;
  logic [OUT_DIV_N-1:0] pwr_q;
  logic [IN_DIV_N-1:0] in_gate_q;
  logic fb_gate_q;
  logic [OUT_DIV_N-1:0] out_gate_q;

  // Bus slave state
  dcp_bus_st_t wst_q;
  dcp_bus_st_t rst_q;
  logic aw_have_q;
  logic w_have_q;
  logic [ADDR_W-1:0] aw_addr_q;
  logic [7:0] w_data_q;
  logic w_lane_q;
  logic awready_q;
  logic wready_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic arready_q;
  logic rvalid_q;
  logic [1:0] rresp_q;
  logic [DATA_W-1:0] rdata_q;

  dcp_div_if div ();

  dcp_out_div_ctrl u_ctrl (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .div(div)
  );

  assign div.power_on = pwr_q;
  assign div.clk_off = out_gate_q;
  assign div.integer_sel = int_mode_q;
  assign div.route = route_q;

  // Write path decode
  wire aw_take = s_axi_awvalid & awready_q;
  wire w_take = s_axi_wvalid & wready_q;
  wire aw_full = aw_have_q | aw_take;
  wire w_full = w_have_q | w_take;
  wire do_write = (wst_q == ST_IDLE) & aw_full & w_full;
  wire [ADDR_W-1:0] wr_addr = aw_take ? s_axi_awaddr : aw_addr_q;
  wire [7:0] wr_data = w_take ? s_axi_wdata[7:0] : w_data_q;
  wire wr_lane = w_take ? s_axi_wstrb[0] : w_lane_q;
  wire [SEL_N-1:0] wr_sel = dec_idx(wr_addr);
  wire wr_hit = |wr_sel;
  wire [SEL_N-1:0] we = (do_write & wr_lane) ? wr_sel : '0;
  wire b_done = bvalid_q & s_axi_bready;

  // Read path decode
  wire ar_take = s_axi_arvalid & arready_q;
  wire r_done = rvalid_q & s_axi_rready;
  wire [SEL_N-1:0] rd_sel = dec_idx(s_axi_araddr);
  wire rd_hit = |rd_sel;
  wire [DATA_W-1:0] status_word = {{(DATA_W-2*OUT_DIV_N){1'b0}}, div.clk_gate_en, div.run};
  wire [DATA_W-1:0] frac_word =
    {{(DATA_W-FB_GATE_BIT-1){1'b0}}, fb_gate_q, 1'b0, in_gate_q};
  wire [DATA_W-1:0] rd_word =
    ({DATA_W{rd_sel[SEL_ROUTE]}} & {{(DATA_W-ROUTE_W){1'b0}}, route_q}) |
    ({DATA_W{rd_sel[SEL_INT_MODE]}} & {{(DATA_W-OUT_DIV_N){1'b0}}, int_mode_q}) |
    ({DATA_W{rd_sel[SEL_PWR]}} & {{(DATA_W-OUT_DIV_N){1'b0}}, pwr_q}) |
    ({DATA_W{rd_sel[SEL_FRAC_GATE]}} & frac_word) |
    ({DATA_W{rd_sel[SEL_OUT_GATE]}} & {{(DATA_W-OUT_DIV_N){1'b0}}, out_gate_q}) |
    ({DATA_W{rd_sel[SEL_STATUS]}} & status_word);

  // Register file
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      route_q <= RST_ROUTE;
      int_mode_q <= RST_INT_MODE;
      pwr_q <= RST_PWR;
      in_gate_q <= RST_IN_GATE;
      fb_gate_q <= RST_FB_GATE;
      out_gate_q <= RST_OUT_GATE;
    end else if (clk_en) begin
      if (we[SEL_ROUTE]) begin
        route_q <= wr_data[ROUTE_W-1:0];
      end
      if (we[SEL_INT_MODE]) begin
        int_mode_q <= wr_data[OUT_DIV_N-1:0];
      end
      if (we[SEL_PWR]) begin
        pwr_q <= wr_data[OUT_DIV_N-1:0];
      end
      if (we[SEL_FRAC_GATE]) begin
        in_gate_q <= wr_data[IN_GATE_LSB +: IN_DIV_N];
        fb_gate_q <= wr_data[FB_GATE_BIT];
      end
      if (we[SEL_OUT_GATE]) begin
        out_gate_q <= wr_data[OUT_DIV_N-1:0];
      end
    end
  end

  // Write channels, address and data in either order
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wst_q <= ST_IDLE;
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      aw_addr_q <= '0;
      w_data_q <= 8'h00;
      w_lane_q <= 1'b0;
      awready_q <= 1'b1;
      wready_q <= 1'b1;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end else if (clk_en) begin
      case (wst_q)
        ST_IDLE: begin
          if (aw_take) begin
            aw_addr_q <= s_axi_awaddr;
          end
          if (w_take) begin
            w_data_q <= s_axi_wdata[7:0];
            w_lane_q <= s_axi_wstrb[0];
          end
          if (do_write) begin
            wst_q <= ST_RESP;
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            awready_q <= 1'b0;
            wready_q <= 1'b0;
            bvalid_q <= 1'b1;
            bresp_q <= wr_hit ? RESP_OKAY : RESP_SLVERR;
          end else begin
            aw_have_q <= aw_full;
            w_have_q <= w_full;
            awready_q <= ~aw_full;
            wready_q <= ~w_full;
          end
        end
        ST_RESP: begin
          if (b_done) begin
            wst_q <= ST_IDLE;
            bvalid_q <= 1'b0;
            awready_q <= 1'b1;
            wready_q <= 1'b1;
          end
        end
        default: begin
          wst_q <= ST_IDLE;
          bvalid_q <= 1'b0;
          awready_q <= 1'b1;
          wready_q <= 1'b1;
        end
      endcase
    end
  end

  // Read channels
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_q <= ST_IDLE;
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rresp_q <= RESP_OKAY;
      rdata_q <= '0;
    end else if (clk_en) begin
      case (rst_q)
        ST_IDLE: begin
          if (ar_take) begin
            rst_q <= ST_RESP;
            arready_q <= 1'b0;
            rvalid_q <= 1'b1;
            rdata_q <= rd_word;
            rresp_q <= rd_hit ? RESP_OKAY : RESP_SLVERR;
          end
        end
        ST_RESP: begin
          if (r_done) begin
            rst_q <= ST_IDLE;
            arready_q <= 1'b1;
            rvalid_q <= 1'b0;
          end
        end
        default: begin
          rst_q <= ST_IDLE;
          arready_q <= 1'b1;
          rvalid_q <= 1'b0;
        end
      endcase
    end
  end

  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp = rresp_q;
  assign s_axi_rdata = rdata_q;

  // Divider controls
  assign out_div_integer_sel = div.mode;
  assign out_div_power_on = pwr_q;
  assign out_div_clk_en = div.clk_gate_en;
  assign out_div_run = div.run;
  assign input_frac_div_clk_off = in_gate_q;
  assign feedback_frac_div_clk_off = fb_gate_q;
  assign out_drv_route = div.route_out;

endmodule

// >>> dcp_divider_cfg_properties.sv
`timescale 1ns/100ps
module dcp_divider_cfg_properties (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic [dcp_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [dcp_pkg::DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [dcp_pkg::OUT_DIV_N-1:0] out_div_integer_sel,
  input wire logic [dcp_pkg::OUT_DIV_N-1:0] out_div_power_on,
  input wire logic [dcp_pkg::OUT_DIV_N-1:0] out_div_clk_en,
  input wire logic [dcp_pkg::OUT_DIV_N-1:0] out_div_run,
  input wire logic [dcp_pkg::IN_DIV_N-1:0] input_frac_div_clk_off,
  input wire logic feedback_frac_div_clk_off,
  input wire logic [dcp_pkg::ROUTE_W-1:0] out_drv_route
);
  import dcp_pkg::*;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // Write taken with both channels at one edge
  wire wr = s_axi_awvalid & s_axi_awready & s_axi_wvalid & s_axi_wready & s_axi_wstrb[0] & clk_en;
  wire [IDX_W-1:0] ix = s_axi_awaddr[ADDR_W-1:2];
  wire [7:0] wd = s_axi_wdata[7:0];
  property p_int; wr && ix == IDX_INT_MODE ##1 clk_en |=> out_div_integer_sel == $past(wd[1:0], 2); endproperty
  a_int: assert property (p_int) else $error("integer select mismatch");
  property p_pwr; wr && ix == IDX_PWR |=> out_div_power_on == $past(wd[1:0]); endproperty
  a_pwr: assert property (p_pwr) else $error("power bits mismatch");
  property p_ing; wr && ix == IDX_FRAC_GATE |=> input_frac_div_clk_off == $past(wd[3:0]); endproperty
  a_ing: assert property (p_ing) else $error("input gate mismatch");
  property p_fbg; wr && ix == IDX_FRAC_GATE |=> feedback_frac_div_clk_off == $past(wd[5]); endproperty
  a_fbg: assert property (p_fbg) else $error("feedback gate mismatch");
  property p_ckg; wr && ix == IDX_OUT_GATE ##1 clk_en |=> out_div_clk_en == ~$past(wd[1:0], 2); endproperty
  a_ckg: assert property (p_ckg) else $error("output clock gate mismatch");
  property p_rte; wr && ix == IDX_ROUTE ##1 clk_en |=> out_drv_route == $past(wd[1:0], 2); endproperty
  a_rte: assert property (p_rte) else $error("route mismatch");
  property p_run; $past(clk_en) |-> out_div_run == ($past(out_div_power_on) & out_div_clk_en); endproperty
  a_run: assert property (p_run) else $error("run mismatch");
  property p_off; out_div_power_on == 2'h0 && clk_en |=> out_div_run == 2'h0; endproperty
  a_off: assert property (p_off) else $error("unpowered divider runs");
endmodule

// >>> dcp_divider_cfg_tb.sv
`timescale 1ns/100ps
module dcp_divider_cfg_tb;
  import dcp_pkg::*;
  logic core_clk, rst_n, clk_en, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, feedback_frac_div_clk_off;
  logic [15:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic [2:0] s_axi_awprot, s_axi_arprot;
  logic [3:0] s_axi_wstrb, e, input_frac_div_clk_off;
  logic [1:0] out_div_integer_sel, out_div_power_on, out_div_clk_en, out_div_run, out_drv_route;
  int n_errors, compares;
  logic [IDX_W-1:0] idx[5] = '{IDX_ROUTE, IDX_INT_MODE, IDX_PWR, IDX_FRAC_GATE, IDX_OUT_GATE};
  logic [7:0] msk[5] = '{8'h03, 8'h03, 8'h03, 8'h2f, 8'h03};
  // Power in [3:2], clock disable in [1:0]
  logic [3:0] cmb[4] = '{4'h4, 4'he, 4'h9, 4'hc};
  dcp_divider_cfg i_dcp_divider_cfg (.*);
  dcp_host_model i_dcp_host_model (.*);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic op(input logic w, input logic [IDX_W-1:0] i, input logic [31:0] v, input logic [1:0] er);
    d = v;
    i_dcp_host_model.xfer(w, {i, 2'h0}, d, r);
    chk(32'(r), 32'(er));
    if (!w && er == RESP_OKAY) chk(d, v);
  endtask
  task automatic close_out;
    $display("Comparisons %0d, mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  initial begin
    #20000;
    n_errors++;
    close_out();
  end
  initial begin
    {rst_n, clk_en, s_axi_awprot, s_axi_arprot, s_axi_wstrb} = {2'h1, 6'h0, 4'hf};
    n_errors = 0;
    compares = 0;
    repeat (4) @(posedge core_clk);
    rst_n <= 1'b1;
    for (int k = 0; k < 5; k++) op(1'b0, idx[k], 32'h0, RESP_OKAY);
    op(1'b0, IDX_STATUS, 32'hc, RESP_OKAY);
    for (int k = 0; k < 5; k++) begin
      op(1'b1, idx[k], 32'hffffffff, RESP_OKAY);
      op(1'b0, idx[k], 32'(msk[k]), RESP_OKAY);
    end
    @(negedge core_clk);
    chk(32'({out_div_integer_sel, out_div_power_on, out_div_clk_en, out_div_run}), 32'hf0);
    chk(32'({input_frac_div_clk_off, feedback_frac_div_clk_off, out_drv_route}), 32'h7f);
    op(1'b1, IDX_INT_MODE, 32'h1, RESP_OKAY);
    op(1'b1, IDX_ROUTE, 32'h2, RESP_OKAY);
    op(1'b1, IDX_FRAC_GATE, 32'h5, RESP_OKAY);
    s_axi_wstrb <= 4'he;
    op(1'b1, IDX_INT_MODE, 32'h2, RESP_OKAY);
    s_axi_wstrb <= 4'hf;
    op(1'b0, IDX_INT_MODE, 32'h1, RESP_OKAY);
    @(negedge core_clk);
    chk(32'({out_div_integer_sel, out_drv_route, input_frac_div_clk_off, feedback_frac_div_clk_off}), 32'hca);
    foreach (cmb[k]) begin
      e = {~cmb[k][1:0], cmb[k][3:2] & ~cmb[k][1:0]};
      op(1'b1, IDX_PWR, 32'(cmb[k][3:2]), RESP_OKAY);
      op(1'b1, IDX_OUT_GATE, 32'(cmb[k][1:0]), RESP_OKAY);
      @(negedge core_clk);
      chk(32'({out_div_power_on, out_div_clk_en, out_div_run}), 32'({cmb[k][3:2], e}));
      op(1'b0, IDX_STATUS, 32'(e), RESP_OKAY);
    end
    op(1'b1, 14'h0, 32'h1, RESP_SLVERR);
    op(1'b0, 14'h0, 32'h0, RESP_SLVERR);
    op(1'b1, IDX_STATUS, 32'h0, RESP_OKAY);
    op(1'b0, IDX_STATUS, 32'hf, RESP_OKAY);
    rst_n <= 1'b0;
    @(posedge core_clk);
    rst_n <= 1'b1;
    op(1'b0, IDX_PWR, 32'h0, RESP_OKAY);
    @(negedge core_clk);
    chk(32'({out_div_integer_sel, out_div_power_on, out_div_clk_en, out_div_run, out_drv_route,
      input_frac_div_clk_off, feedback_frac_div_clk_off}), 32'h600);
    close_out();
  end
endmodule
bind dcp_divider_cfg dcp_divider_cfg_properties i_dcp_divider_cfg_properties (.*);

// >>> dcp_host_model.sv
`timescale 1ns/100ps
module dcp_host_model (
  input wire logic core_clk,
  output logic [15:0] s_axi_awaddr,
  output logic s_axi_awvalid,
  input wire logic s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  output logic s_axi_bready,
  output logic [15:0] s_axi_araddr,
  output logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  output logic s_axi_rready
);
  initial {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
  initial {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
  // One write or one read; each channel released at its own handshake
  task automatic xfer(input logic w, input logic [15:0] a, inout logic [31:0] d, output logic [1:0] r);
    logic pa, pw, pb, ha, hw, hb;
    {pa, pw, pb} = {1'b1, w, 1'b1};
    @(posedge core_clk);
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= {a, a, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {w, w, w};
    {s_axi_arvalid, s_axi_rready} <= {!w, !w};
    while (pa || pw || pb) begin
      @(negedge core_clk);
      ha = pa && (w ? s_axi_awready : s_axi_arready);
      hw = pw && s_axi_wready;
      hb = !pa && !pw && (w ? s_axi_bvalid : s_axi_rvalid);
      {d, r} = w ? {d, s_axi_bresp} : {s_axi_rdata, s_axi_rresp};
      @(posedge core_clk);
      if (ha) {s_axi_awvalid, s_axi_arvalid} <= 2'h0;
      if (hw) s_axi_wvalid <= 1'b0;
      if (hb) {s_axi_bready, s_axi_rready} <= 2'h0;
      {pa, pw, pb} = {pa && !ha, pw && !hw, pb && !hb};
    end
  endtask
endmodule

// >>> dcp_out_div_ctrl.sv
`timescale 1ns/100ps
module dcp_out_div_ctrl (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  dcp_div_if.ctrl div
);
  import dcp_pkg::*;

  logic [OUT_DIV_N-1:0] run_q;
  logic [OUT_DIV_N-1:0] gate_q;
  logic [OUT_DIV_N-1:0] mode_q;
  logic [ROUTE_W-1:0] route_q;

  genvar g;
  generate
    for (g = 0; g < OUT_DIV_N; g++) begin : g_div
      always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
          run_q[g] <= 1'b0;
          gate_q[g] <= 1'b0;
          mode_q[g] <= 1'b0;
        end else if (clk_en) begin
          run_q[g] <= div.power_on[g] & ~div.clk_off[g];
          gate_q[g] <= ~div.clk_off[g];
          mode_q[g] <= div.integer_sel[g];
        end
      end
    end
  endgenerate

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      route_q <= RST_ROUTE;
    end else if (clk_en) begin
      route_q <= div.route;
    end
  end

  assign div.run = run_q;
  assign div.clk_gate_en = gate_q;
  assign div.mode = mode_q;
  assign div.route_out = route_q;

endmodule

// >>> dcp_pkg.sv
package dcp_pkg;

  localparam int ADDR_W = 16;
  localparam int DATA_W = 32;
  localparam int IDX_W = 14;

  // Register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_ROUTE = 14'h0a03;
  localparam logic [IDX_W-1:0] IDX_INT_MODE = 14'h0a04;
  localparam logic [IDX_W-1:0] IDX_PWR = 14'h0a05;
  localparam logic [IDX_W-1:0] IDX_FRAC_GATE = 14'h0b44;
  localparam logic [IDX_W-1:0] IDX_OUT_GATE = 14'h0b4a;
  localparam logic [IDX_W-1:0] IDX_STATUS = 14'h0c00;

  // Decode one-hot positions
  localparam int SEL_ROUTE = 0;
  localparam int SEL_INT_MODE = 1;
  localparam int SEL_PWR = 2;
  localparam int SEL_FRAC_GATE = 3;
  localparam int SEL_OUT_GATE = 4;
  localparam int SEL_STATUS = 5;
  localparam int SEL_N = 6;

  // Field layout
  localparam int OUT_DIV_N = 2;
  localparam int IN_DIV_N = 4;
  localparam int ROUTE_W = 2;
  localparam int IN_GATE_LSB = 0;
  localparam int FB_GATE_BIT = 5;

  // Reset values
  localparam logic [ROUTE_W-1:0] RST_ROUTE = 2'h0;
  localparam logic [OUT_DIV_N-1:0] RST_INT_MODE = 2'h0;
  localparam logic [OUT_DIV_N-1:0] RST_PWR = 2'h0;
  localparam logic [IN_DIV_N-1:0] RST_IN_GATE = 4'h0;
  localparam logic RST_FB_GATE = 1'b0;
  localparam logic [OUT_DIV_N-1:0] RST_OUT_GATE = 2'h0;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_RESP = 2'b10
  } dcp_bus_st_t;

endpackage
